/* hdl/flc_consts.svh */
// Constants for the parallel NOR flash command and protection controller
`ifndef FLC_CONSTS_SVH
`define FLC_CONSTS_SVH

// -----------------------------------------------------------------
// Widths and clock
// -----------------------------------------------------------------
`define FLC_ADDR_W 19
`define FLC_DATA_W 16
`define FLC_SECT_W 7
`define FLC_CNT_W 8
`define FLC_CLK_MHZ 20

// -----------------------------------------------------------------
// Bus timing, in ns and in derived cycles
// -----------------------------------------------------------------
`define FLC_TACC_NS 100
`define FLC_TWP_NS 60
`define FLC_TACC_CYC ((`FLC_TACC_NS * `FLC_CLK_MHZ + 999) / 1000)
`define FLC_TWP_CYC ((`FLC_TWP_NS * `FLC_CLK_MHZ + 999) / 1000)
`define FLC_SYNC_LAT 4

// -----------------------------------------------------------------
// Command cycles and special addresses
// -----------------------------------------------------------------
`define FLC_UL1_ADDR 19'h00555
`define FLC_UL2_ADDR 19'h002aa
`define FLC_UL1_DATA 16'h00aa
`define FLC_UL2_DATA 16'h0055
`define FLC_PROG_CMD 16'h00a0
`define FLC_ID_CMD 16'h0090
`define FLC_RESET_CMD 16'h00f0
`define FLC_UNPROT_CMD 16'h0060
`define FLC_RESET_ADDR 19'h00000
`define FLC_PROT_OFS 12'h002
`define FLC_OFS_W 12

// -----------------------------------------------------------------
// Status bit positions and reset values
// -----------------------------------------------------------------
`define FLC_POLL_BIT 7
`define FLC_TO_BIT 5
`define FLC_STEP_ZERO 2'h0
`define FLC_CNT_ZERO 8'h00

`endif

/* hdl/flc_pkg.sv */
// Types shared by the flash controller modules
`include "flc_consts.svh"
package flc_pkg;

	// User operations
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_RESET = 3'h2,
		OP_ID_ENTER = 3'h3,
		OP_ID_READ = 3'h4,
		OP_PROT_CHK = 3'h5,
		OP_HV_READ = 3'h6,
		OP_UNPROT = 3'h7
	} flc_op_t;

	// Bus sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WSETUP = 3'h1,
		ST_WLOW = 3'h2,
		ST_WHIGH = 3'h3,
		ST_WEND = 3'h4,
		ST_RSETUP = 3'h5,
		ST_RGAP = 3'h6
	} flc_state_t;

	// One write cycle of a command script
	typedef struct packed {
		logic last;
		logic [`FLC_ADDR_W-1:0] addr;
		logic [`FLC_DATA_W-1:0] data;
	} flc_step_t;

endpackage

/* hdl/flc_pin_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module flc_pin_sync #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins and filtered result
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;
	logic [W-1:0] out_d;

	// Take each bit once the last two stages agree
	always_comb begin
		out_d = out_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	// Stage registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_o = out_q;
endmodule

/* hdl/flc_ctrl.sv */
// Host-side controller driving a parallel NOR flash through its pins
`timescale 1ns/1ps
`include "flc_consts.svh"
// Contract
// - Pin method holds A9 at high voltage with A6, A1, A0 set before reading.
// - Protection check puts sector on top address bits; zero means unprotected.
// - Every sector must be protected before the first unprotect write.
// - A write needs chip select and write strobe low, output enable high.
// - Identification mode is left only by writing a reset; the controller also clears it on rst_i, which pulls rst_n_o low.
// - On timeout flag during program or erase, write a reset.
module flc_ctrl import flc_pkg::*; #(
	parameter int AW = `FLC_ADDR_W,
	parameter int DW = `FLC_DATA_W,
	parameter int SW = `FLC_SECT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// User request port
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire flc_op_t req_op_i,
	input wire logic [AW-1:0] req_addr_i,
	input wire logic [DW-1:0] req_data_i,
	// User answer port
	output logic rsp_valid_o,
	output logic rsp_err_o,
	output logic [DW-1:0] rsp_data_o,
	// User mode controls and status
	input wire logic temp_unprot_i,
	input wire logic all_prot_i,
	output logic id_mode_o,
	// Flash pins
	output logic [AW-1:0] addr_o,
	output logic [DW-1:0] dq_o,
	output logic dq_oe_o,
	input wire logic [DW-1:0] dq_i,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic a9_hv_o,
	output logic rst_hv_o,
	output logic rst_n_o
);
	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	localparam logic [`FLC_CNT_W-1:0] TWP_LAST = `FLC_CNT_W'(`FLC_TWP_CYC - 1);
	localparam logic [`FLC_CNT_W-1:0] RD_LAST =
		`FLC_CNT_W'(`FLC_TACC_CYC + `FLC_SYNC_LAT - 1);

	flc_state_t state_q, state_d;
	flc_op_t op_q, op_d;
	logic [AW-1:0] arg_q, arg_d, addr_q, addr_d;
	logic [DW-1:0] wdat_q, wdat_d, dq_q, dq_d, rdat_q, rdat_d;
	logic [1:0] step_q, step_d;
	logic [`FLC_CNT_W-1:0] cnt_q, cnt_d;
	logic poll_q, poll_d, to_q, to_d, fail_q, fail_d, id_q, id_d;
	logic rv_q, rv_d, rerr_q, rerr_d;
	logic dq_oe_q, dq_oe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
	logic a9_q, a9_d, hv_q, hv_d, rstn_q;
	logic [DW-1:0] dq_s;
	flc_step_t cur, nxt;

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Write script of each operation
	function automatic flc_step_t step_f(flc_op_t op, logic [1:0] idx,
			logic [AW-1:0] a, logic [DW-1:0] d);
		flc_step_t s;
		s = '{last: 1'b0, addr: `FLC_UL1_ADDR, data: `FLC_UL1_DATA};
		if (op == OP_RESET) begin
			s = '{last: 1'b1, addr: `FLC_RESET_ADDR, data: `FLC_RESET_CMD};
		end else if (op == OP_UNPROT) begin
			s = '{last: 1'b1, addr: a, data: `FLC_UNPROT_CMD};
		end else if (idx == 2'h1) begin
			s = '{last: 1'b0, addr: `FLC_UL2_ADDR, data: `FLC_UL2_DATA};
		end else if (idx == 2'h2 && op == OP_ID_ENTER) begin
			s = '{last: 1'b1, addr: `FLC_UL1_ADDR, data: `FLC_ID_CMD};
		end else if (idx == 2'h2) begin
			s = '{last: 1'b0, addr: `FLC_UL1_ADDR, data: `FLC_PROG_CMD};
		end else if (idx == 2'h3) begin
			s = '{last: 1'b1, addr: a, data: d};
		end
		return s;
	endfunction

	// Read address of each operation
	function automatic logic [AW-1:0] rd_addr_f(flc_op_t op, logic [AW-1:0] a);
		if (op == OP_PROT_CHK) begin
			return {a[SW-1:0], (AW-SW)'(`FLC_PROT_OFS)};
		end
		return a;
	endfunction

	// -----------------------------------------------------------------
	// Data pin synchroniser
	// -----------------------------------------------------------------
	flc_pin_sync #(
		.W(DW)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(dq_i),
		.sync_o(dq_s)
	);

	// -----------------------------------------------------------------
	// Sequencer next state
	// -----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		arg_d = arg_q;
		wdat_d = wdat_q;
		step_d = step_q;
		cnt_d = cnt_q;
		poll_d = poll_q;
		to_d = to_q;
		fail_d = fail_q;
		id_d = id_q;
		rv_d = 1'b0;
		rerr_d = 1'b0;
		rdat_d = rdat_q;
		cur = step_f(op_q, step_q, arg_q, wdat_q);
		unique case (state_q)
			ST_IDLE: begin
				if (req_valid_i) begin
					op_d = req_op_i;
					arg_d = req_addr_i;
					wdat_d = req_data_i;
					step_d = `FLC_STEP_ZERO;
					cnt_d = `FLC_CNT_ZERO;
					to_d = 1'b0;
					if ((id_q && (req_op_i == OP_READ || req_op_i == OP_PROG ||
							req_op_i == OP_ID_ENTER)) ||
							(!id_q && (req_op_i == OP_ID_READ || req_op_i == OP_PROT_CHK)) ||
							(req_op_i == OP_UNPROT && !all_prot_i)) begin
						rv_d = 1'b1;
						rerr_d = 1'b1;
					end else if (req_op_i == OP_PROG || req_op_i == OP_RESET ||
							req_op_i == OP_ID_ENTER || req_op_i == OP_UNPROT) begin
						state_d = ST_WSETUP;
					end else begin
						state_d = ST_RSETUP;
					end
				end
			end
			ST_WSETUP: begin
				state_d = ST_WLOW;
				cnt_d = `FLC_CNT_ZERO;
			end
			ST_WLOW: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == TWP_LAST) begin
					state_d = ST_WHIGH;
				end
			end
			ST_WHIGH: begin
				state_d = ST_WEND;
			end
			ST_WEND: begin
				cnt_d = `FLC_CNT_ZERO;
				if (!cur.last) begin
					step_d = step_q + 1'b1;
					state_d = ST_WSETUP;
				end else if (op_q == OP_PROG) begin
					poll_d = 1'b1;
					state_d = ST_RGAP;
				end else begin
					if (op_q == OP_RESET) begin
						id_d = 1'b0;
					end
					if (op_q == OP_ID_ENTER) begin
						id_d = 1'b1;
					end
					rv_d = 1'b1;
					rerr_d = fail_q;
					fail_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			ST_RSETUP: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == RD_LAST) begin
					cnt_d = `FLC_CNT_ZERO;
					if (!poll_q) begin
						rdat_d = dq_s;
						if (op_q != OP_READ) begin
							rdat_d = {{(DW-8){1'b0}}, dq_s[7:0]};
						end
						rv_d = 1'b1;
						state_d = ST_IDLE;
					end else if (dq_s[`FLC_POLL_BIT] == wdat_q[`FLC_POLL_BIT]) begin
						poll_d = 1'b0;
						rdat_d = dq_s;
						rv_d = 1'b1;
						state_d = ST_IDLE;
					end else if (dq_s[`FLC_TO_BIT] && to_q) begin
						poll_d = 1'b0;
						fail_d = 1'b1;
						op_d = OP_RESET;
						step_d = `FLC_STEP_ZERO;
						state_d = ST_WSETUP;
					end else begin
						to_d = dq_s[`FLC_TO_BIT];
						state_d = ST_RGAP;
					end
				end
			end
			ST_RGAP: begin
				state_d = ST_RSETUP;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// Pin values for the coming cycle
	// -----------------------------------------------------------------
	always_comb begin
		nxt = step_f(op_d, step_d, arg_d, wdat_d);
		ce_n_d = !(state_d == ST_WSETUP || state_d == ST_WLOW ||
			state_d == ST_WHIGH || state_d == ST_RSETUP);
		we_n_d = (state_d != ST_WLOW);
		oe_n_d = (state_d != ST_RSETUP);
		dq_oe_d = (state_d == ST_WSETUP || state_d == ST_WLOW ||
			state_d == ST_WHIGH || state_d == ST_WEND);
		a9_d = (state_d == ST_RSETUP && op_d == OP_HV_READ);
		hv_d = temp_unprot_i || (op_d == OP_UNPROT && state_d != ST_IDLE);
		addr_d = addr_q;
		dq_d = dq_q;
		if (dq_oe_d) begin
			addr_d = nxt.addr;
			dq_d = nxt.data;
		end else if (state_d == ST_RSETUP) begin
			addr_d = rd_addr_f(op_d, arg_d);
		end
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			arg_q <= '0;
			wdat_q <= '0;
			step_q <= `FLC_STEP_ZERO;
			cnt_q <= `FLC_CNT_ZERO;
			poll_q <= 1'b0;
			to_q <= 1'b0;
			fail_q <= 1'b0;
			id_q <= 1'b0;
			rv_q <= 1'b0;
			rerr_q <= 1'b0;
			rdat_q <= '0;
			addr_q <= '0;
			dq_q <= '0;
			dq_oe_q <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			a9_q <= 1'b0;
			hv_q <= 1'b0;
			rstn_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			arg_q <= arg_d;
			wdat_q <= wdat_d;
			step_q <= step_d;
			cnt_q <= cnt_d;
			poll_q <= poll_d;
			to_q <= to_d;
			fail_q <= fail_d;
			id_q <= id_d;
			rv_q <= rv_d;
			rerr_q <= rerr_d;
			rdat_q <= rdat_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			dq_oe_q <= dq_oe_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			a9_q <= a9_d;
			hv_q <= hv_d;
			rstn_q <= 1'b1;
		end
	end

	// Outputs
	assign req_ready_o = (state_q == ST_IDLE);
	assign rsp_valid_o = rv_q;
	assign rsp_err_o = rerr_q;
	assign rsp_data_o = rdat_q;
	assign id_mode_o = id_q;
	assign addr_o = addr_q;
	assign dq_o = dq_q;
	assign dq_oe_o = dq_oe_q;
	assign ce_n_o = ce_n_q;
	assign oe_n_o = oe_n_q;
	assign we_n_o = we_n_q;
	assign a9_hv_o = a9_q;
	assign rst_hv_o = hv_q;
	assign rst_n_o = rstn_q;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_write_combo: assert property (@(posedge clk_i) disable iff (rst_i)
		!we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o)
		else $error("write strobe without select or with output enable");
	a_addr_held: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(we_n_o) |-> $stable(addr_o) && $past(!ce_n_o))
		else $error("address not set up before strobe fell");
	a_data_held: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(we_n_o) |-> $stable(dq_o) ##1 dq_oe_o && $stable(dq_o))
		else $error("write data not held across strobe rise");
	a_powerup_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> we_n_o && ce_n_o && req_ready_o)
		else $error("strobes active at reset release");
	a_hv_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
		a9_hv_o |-> we_n_o && !oe_n_o && op_q == OP_HV_READ)
		else $error("high voltage on A9 outside a pin-method read");
	a_prot_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		(!oe_n_o && op_q == OP_PROT_CHK) |->
		addr_o[`FLC_OFS_W-1:0] == `FLC_PROT_OFS && addr_o[AW-1 -: SW] == arg_q[SW-1:0])
		else $error("protection check address malformed");
	a_id_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(id_mode_o) |-> op_q == OP_RESET && $past(state_q) == ST_WEND)
		else $error("identification mode left without a reset write");
	a_unprot_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_IDLE && req_valid_i && req_op_i == OP_UNPROT && !all_prot_i)
		|=> rsp_valid_o && rsp_err_o && state_q == ST_IDLE)
		else $error("unprotect issued before all sectors protected");
	a_timeout_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == ST_RSETUP && poll_q && cnt_q == RD_LAST && to_q &&
		dq_s[`FLC_TO_BIT] && dq_s[`FLC_POLL_BIT] != wdat_q[`FLC_POLL_BIT])
		|=> op_q == OP_RESET ##1 !we_n_o)
		else $error("no reset written after timeout flag");
	a_hv_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(temp_unprot_i) |-> rst_hv_o)
		else $error("reset pin high voltage dropped during temporary unprotect");
endmodule

/* test/flc_flash_model.sv */
// Behavioural parallel NOR flash with command states and sector protection
`timescale 1ns/1ps
module flc_flash_model #(
	parameter logic [7:0] MAKER = 8'h5a, // Arbitrary maker code
	parameter int PROG_NS = 3000
) (
	// Bus pins
	input wire logic [18:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	// Strobes and high-voltage controls
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic a9_hv_i,
	input wire logic rst_hv_i,
	input wire logic rst_n_i,
	// Next program never finishes and raises the timeout flag
	input wire logic fail_i
);
	logic [15:0] mem [256];
	logic prot [128];
	logic [18:0] wa;
	logic [15:0] wd, pd, val, held;
	logic [7:0] pa;
	logic [1:0] step;
	logic id_q, arm, busy, failing, live;
	wire wr = !ce_n_i && !we_n_i && oe_n_i;
	wire drv = !ce_n_i && !oe_n_i && rst_n_i;

	// Delivered state: read-array, no sector protected
	initial begin
		foreach (mem[i]) mem[i] = {8'hc3, 8'(i)};
		foreach (prot[i]) prot[i] = 1'b0;
		{step, id_q, arm, busy, failing} = '0;
		held = '0;
	end

	// Address taken when the later strobe falls
	// A write begun while the reset pin is low is not taken
	always @(posedge wr) begin
		wa = addr_i;
		live = rst_n_i;
	end

	// Hardware reset pin returns to read-array
	always @(negedge rst_n_i) {step, id_q, arm, busy, failing} = '0;

	// Command decode on the first rising strobe; ignored while programming unless the program has failed
	always @(negedge wr) begin
		wd = dq_i;
		if (live && (!busy || failing)) begin
			if (wd[7:0] == 8'hf0) begin
				{step, id_q, arm, busy, failing} = '0;
			end else if (arm) begin
				arm = 1'b0;
				if (!prot[wa[18:12]] || rst_hv_i) begin
					pa = wa[7:0];
					pd = wd;
					failing = fail_i;
					busy = 1'b1;
				end
			end else if (rst_hv_i && wd[7:0] == 8'h60) begin
				prot[wa[18:12]] = 1'b0;
			end else if (step == 2'h2 && wa == 19'h00555) begin
				id_q = id_q || wd[7:0] == 8'h90;
				arm = wd[7:0] == 8'ha0 && !id_q;
				step = 2'h0;
			end else if (step == 2'h0 && wa == 19'h00555 && wd[7:0] == 8'haa) begin
				step = 2'h1;
			end else begin
				step = (step == 2'h1 && wa == 19'h002aa && wd[7:0] == 8'h55) ? 2'h2 : 2'h0;
			end
		end
	end

	// Embedded program ends by itself unless told to fail
	always @(posedge busy) begin
		#(PROG_NS);
		if (busy && !failing) begin
			mem[pa] = pd;
			busy = 1'b0;
		end
	end

	// Status while busy, codes in identification mode or with A9 high voltage, else array data
	always_comb begin
		if (busy)
			val = {8'h00, ~pd[7], 1'b0, failing, 5'h00};
		else if (id_q || a9_hv_i)
			val = (addr_i[7:0] == 8'h00) ? {8'h00, MAKER} :
				{15'h0000, addr_i[1:0] == 2'h2 && prot[addr_i[18:12]]};
		else
			val = mem[addr_i[7:0]];
	end

	// Released bus shows the inverse of the last driven word
	always @(val or drv) begin
		if (drv)
			held = val;
	end
	assign dq_o = drv ? val : ~held;
endmodule

/* test/tb_flash_command_protect_ctrl.sv */
// Self-checking testbench for the flash command and protection controller
`timescale 1ns/1ps
module tb_flash_command_protect_ctrl import flc_pkg::*; ();
	localparam logic [7:0] MAKER = 8'h5a; // Arbitrary maker code
	localparam int LIMIT = 20000;
	logic clk_i, rst_i, req_valid_i, temp_unprot_i, all_prot_i, fail;
	flc_op_t req_op_i;
	logic [18:0] req_addr_i, addr_o;
	logic [15:0] req_data_i, rsp_data_o, dq_o, mdl_dq, dq_bus;
	logic req_ready_o, rsp_valid_o, rsp_err_o, id_mode_o, dq_oe_o;
	logic ce_n_o, oe_n_o, we_n_o, a9_hv_o, rst_hv_o, rst_n_o;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	assign dq_bus = dq_oe_o ? dq_o : mdl_dq;

	flc_ctrl dut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i,
		.req_data_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o, .temp_unprot_i, .all_prot_i,
		.id_mode_o, .addr_o, .dq_o, .dq_oe_o, .dq_i(dq_bus), .ce_n_o, .oe_n_o, .we_n_o,
		.a9_hv_o, .rst_hv_o, .rst_n_o);
	flc_flash_model #(.MAKER(MAKER)) flash (.addr_i(addr_o), .dq_i(dq_bus), .dq_o(mdl_dq),
		.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .a9_hv_i(a9_hv_o),
		.rst_hv_i(rst_hv_o), .rst_n_i(rst_n_o), .fail_i(fail));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One request, answer awaited under a bound, then judged
	task automatic run(input flc_op_t op, input logic [18:0] a, input logic [15:0] d,
			input logic err, input logic chk, input logic [15:0] exp);
		int n;
		// One edge since the last answer, then wait for idle before raising valid
		@(posedge clk_i);
		#1;
		while (req_ready_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		req_op_i = op;
		req_addr_i = a;
		req_data_i = d;
		req_valid_i = 1'b1;
		@(posedge clk_i);
		#1 req_valid_i = 1'b0;
		for (n = 0; n < 2000 && rsp_valid_o !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		check("rsp_valid", {15'h0000, rsp_valid_o}, 16'h0001);
		check("rsp_err", {15'h0000, rsp_err_o}, {15'h0000, err});
		if (chk)
			check("rsp_data", rsp_data_o, exp);
	endtask

	// Array read after reset, refusal of an identification read outside its mode and of an unprotect before all sectors are protected
	task automatic t_basic();
		run(OP_READ, 19'h00010, 16'h0000, 1'b0, 1'b1, 16'hc310);
		run(OP_ID_READ, 19'h00000, 16'h0000, 1'b1, 1'b0, 16'h0000);
		run(OP_UNPROT, 19'h03000, 16'h0000, 1'b1, 1'b0, 16'h0000);
	endtask

	// Program, refused in a protected sector unless reset pin is raised
	task automatic t_prog();
		run(OP_PROG, 19'h00021, 16'h1234, 1'b0, 1'b0, 16'h0000);
		run(OP_READ, 19'h00021, 16'h0000, 1'b0, 1'b1, 16'h1234);
		flash.prot[3] = 1'b1;
		run(OP_PROG, 19'h03080, 16'h00ff, 1'b0, 1'b0, 16'h0000);
		run(OP_READ, 19'h03080, 16'h0000, 1'b0, 1'b1, 16'hc380);
		temp_unprot_i = 1'b1;
		run(OP_PROG, 19'h03080, 16'h00ff, 1'b0, 1'b0, 16'h0000);
		temp_unprot_i = 1'b0;
		run(OP_READ, 19'h03080, 16'h0000, 1'b0, 1'b1, 16'h00ff);
		run(OP_PROG, 19'h03080, 16'h0080, 1'b0, 1'b0, 16'h0000);
		run(OP_READ, 19'h03080, 16'h0000, 1'b0, 1'b1, 16'h00ff);
	endtask

	// Identification entered by command, left only by reset
	task automatic t_ident();
		run(OP_ID_ENTER, 19'h00000, 16'h0000, 1'b0, 1'b0, 16'h0000);
		check("id_mode", {15'h0000, id_mode_o}, 16'h0001);
		run(OP_ID_READ, 19'h00000, 16'h0000, 1'b0, 1'b1, {8'h00, MAKER});
		run(OP_ID_READ, 19'h05100, 16'h0000, 1'b0, 1'b1, {8'h00, MAKER});
		run(OP_PROT_CHK, 19'h00003, 16'h0000, 1'b0, 1'b1, 16'h0001);
		run(OP_PROT_CHK, 19'h00004, 16'h0000, 1'b0, 1'b1, 16'h0000);
		run(OP_READ, 19'h00010, 16'h0000, 1'b1, 1'b0, 16'h0000);
		run(OP_RESET, 19'h00000, 16'h0000, 1'b0, 1'b0, 16'h0000);
		check("id_mode", {15'h0000, id_mode_o}, 16'h0000);
		run(OP_READ, 19'h00010, 16'h0000, 1'b0, 1'b1, 16'hc310);
	endtask

	// Program that times out is cleaned up by a reset write
	task automatic t_timeout();
		fail = 1'b1;
		run(OP_PROG, 19'h00044, 16'h0000, 1'b1, 1'b0, 16'h0000);
		fail = 1'b0;
		run(OP_READ, 19'h00044, 16'h0000, 1'b0, 1'b1, 16'hc344);
	endtask

	// Pin-method reads, then unprotect once every sector is protected
	task automatic t_hv_unprot();
		run(OP_HV_READ, 19'h00000, 16'h0000, 1'b0, 1'b1, {8'h00, MAKER});
		run(OP_HV_READ, 19'h03002, 16'h0000, 1'b0, 1'b1, 16'h0001);
		for (int i = 0; i < 128; i++) flash.prot[i] = 1'b1;
		all_prot_i = 1'b1;
		run(OP_UNPROT, 19'h03000, 16'h0000, 1'b0, 1'b0, 16'h0000);
		run(OP_HV_READ, 19'h03002, 16'h0000, 1'b0, 1'b1, 16'h0000);
		run(OP_HV_READ, 19'h05002, 16'h0000, 1'b0, 1'b1, 16'h0001);
		run(OP_PROG, 19'h03011, 16'h4321, 1'b0, 1'b0, 16'h0000);
		run(OP_READ, 19'h03011, 16'h0000, 1'b0, 1'b1, 16'h4321);
	endtask

	// Mid-run reset leaves identification mode and returns the flash to read-array
	task automatic t_midreset();
		run(OP_ID_ENTER, 19'h00000, 16'h0000, 1'b0, 1'b0, 16'h0000);
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 check("rst_n", {15'h0000, rst_n_o}, 16'h0000);
		check("id_mode", {15'h0000, id_mode_o}, 16'h0000);
		rst_i = 1'b0;
		run(OP_READ, 19'h00010, 16'h0000, 1'b0, 1'b1, 16'hc310);
		check("rst_n", {15'h0000, rst_n_o}, 16'h0001);
	endtask

	// Main sequence
	initial begin
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_op_i = OP_READ;
		req_addr_i = '0;
		req_data_i = '0;
		temp_unprot_i = 1'b0;
		all_prot_i = 1'b0;
		fail = 1'b0;
		repeat (4) @(posedge clk_i);
		#1 rst_i = 1'b0;
		t_basic();
		t_prog();
		t_ident();
		t_timeout();
		t_hv_unprot();
		t_midreset();
		tally_and_finish();
	end
endmodule
